// ---- design/vtm_pkg.sv ----
package vtm_pkg;

  // ----------------------------------------------------------------------
  // register map (byte addresses, one aligned word each)
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_TABLE_BASE_LO = 8'h00;
  localparam logic [7:0] ADDR_TABLE_BASE_HI = 8'h04;
  localparam logic [7:0] ADDR_TABLE_CFG     = 8'h08;
  localparam logic [7:0] ADDR_ELEMENT_MAP   = 8'h0c;
  localparam logic [7:0] ADDR_STATUS        = 8'h10;
  localparam logic [7:0] ADDR_ID4           = 8'h14;
  localparam logic [7:0] ADDR_ERROR         = 8'h18;
  localparam logic [7:0] ADDR_PAS_BASE_LO   = 8'h1c;
  localparam logic [7:0] ADDR_PAS_BASE_HI   = 8'h20;
  localparam logic [7:0] ADDR_PAS_LIMIT_LO  = 8'h24;
  localparam logic [7:0] ADDR_PAS_LIMIT_HI  = 8'h28;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int CFG_VALID_BIT    = 0;
  localparam int CFG_IDW_LSB      = 8;
  localparam int CFG_IDW_W        = 5;
  localparam int STATUS_IDLE_BIT  = 0;
  localparam int ENTRY_VALID_BIT  = 0;
  localparam int ERR_RANGE_BIT    = 0;
  localparam int ERR_PAS_BIT      = 1;
  localparam int ERR_BUSY_BIT     = 2;

  // ----------------------------------------------------------------------
  // sizes and reset values
  // ----------------------------------------------------------------------
  localparam int          ENTRY_BYTES     = 8;
  localparam int          ENTRY_SHIFT     = 3;
  localparam int          ADDR_W          = 48;
  localparam int          MAX_IDW         = 16;
  localparam logic [31:0] RESET_WORD      = 32'h0000_0000;
  localparam logic [31:0] UNMAPPED_WORD   = 32'h0000_0000;

  typedef enum logic [3:0] {
    VTM_IDLE  = 4'b0001,
    VTM_READ  = 4'b0010,
    VTM_WRITE = 4'b0100,
    VTM_DONE  = 4'b1000
  } vtm_state_type;

  typedef struct packed {
    logic              rd;
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [63:0]       wdata;
  } vtm_mem_req_type;

endpackage : vtm_pkg

// ---- design/vtm_addr_guard.sv ----
`timescale 1ns/10ps
module vtm_addr_guard
  import vtm_pkg::*;
(
  input  wire logic [ADDR_W-1:0]   table_base,
  input  wire logic [CFG_IDW_W-1:0] id_width,
  input  wire logic [15:0]         element_id,
  input  wire logic [ADDR_W-1:0]   pas_base,
  input  wire logic [ADDR_W-1:0]   pas_limit,
  output logic      [ADDR_W-1:0]   entry_addr,
  output logic                     in_range,
  output logic                     in_pas
);

  logic [ADDR_W-1:0] offset;

  always_comb
  begin
    offset     = ADDR_W'(element_id) << ENTRY_SHIFT;
    entry_addr = table_base + offset;  // RULE12
    in_range   = (id_width <= CFG_IDW_W'(MAX_IDW)) &&
                 ((32'(element_id) >> id_width) == 32'h0);  // RULE13
    in_pas     = (entry_addr >= pas_base) &&
                 ((entry_addr + ADDR_W'(ENTRY_BYTES - 1)) <= pas_limit)
                 && (entry_addr >= table_base);  // RULE2
  end

endmodule : vtm_addr_guard

// ---- design/vtm_table_mgr.sv ----
`timescale 1ns/10ps
// Notes on behaviour
// RULE1: software avoids writing entries while mapping is busy.
// RULE2: no memory access ever leaves the configured address window.
// RULE3: software leaves valid entries untouched.
// RULE4: software zeroes the descriptor before validating an element.
// RULE5: nonzero descriptor may or may not yield a candidate.
// RULE6: nonzero descriptor leaves element configuration unknown.
// RULE7: descriptor stays put while the owning machine is valid.
// RULE8: descriptor layout is ours alone; this block never reads it.
// RULE9: descriptor size is readable in the fourth identification register.
// RULE10: descriptor size is identical in every domain with machines.
// RULE11: every service instance reports the same descriptor size.
// RULE12: entries are eight bytes, laid at eight-byte stride.
// RULE13: table holds two to the identifier width entries.
// RULE14: clear idle, write valid bit, then set idle, in order.
// RULE15: software prepares entry invalid, maps, then waits for idle.
// RULE16: entry address is base plus id times eight, bounded.
module vtm_table_mgr
  import vtm_pkg::*;
#(
  parameter logic [15:0] DESC_SIZE = 16'h0040  // plain default, fixed per system
)
(
  input  wire logic                 clk_sys,
  input  wire logic                 arst_n,
  input  wire logic [7:0]           avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  output logic      [31:0]          avs_readdata,
  output logic                      avs_waitrequest,
  output vtm_mem_req_type           mem_req,
  input  wire logic                 mem_ack,
  input  wire logic [63:0]          mem_rdata
);

  if (DESC_SIZE == 16'h0000)
  begin : g_size_check
    $error("descriptor size must be nonzero");
  end

  // ----------------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------------
  logic [ADDR_W-1:0]    table_base, next_table_base;
  logic                 table_valid, next_table_valid;
  logic [CFG_IDW_W-1:0] id_width, next_id_width;
  logic [ADDR_W-1:0]    pas_base, next_pas_base;
  logic [ADDR_W-1:0]    pas_limit, next_pas_limit;
  logic [15:0]          element_id, next_element_id;
  logic                 idle, next_idle;
  logic [2:0]           err, next_err;
  logic [31:0]          next_readdata;
  logic                 next_waitrequest;
  vtm_state_type        state, next_state;
  vtm_mem_req_type      next_mem_req;
  logic [ADDR_W-1:0]    entry_addr;
  logic                 in_range;
  logic                 in_pas;
  logic                 bus_req;

  vtm_addr_guard u_guard (
    .table_base (table_base),
    .id_width   (id_width),
    .element_id (element_id),
    .pas_base   (pas_base),
    .pas_limit  (pas_limit),
    .entry_addr (entry_addr),
    .in_range   (in_range),
    .in_pas     (in_pas)
  );

  // waitrequest is high at rest; a request is answered one cycle after it rises
  assign bus_req = (avs_read || avs_write) && avs_waitrequest;

  // ----------------------------------------------------------------------
  // bus slave and mapping sequencer
  // ----------------------------------------------------------------------
  always_comb
  begin
    next_table_base  = table_base;
    next_table_valid = table_valid;
    next_id_width    = id_width;
    next_pas_base    = pas_base;
    next_pas_limit   = pas_limit;
    next_element_id  = element_id;
    next_idle        = idle;
    next_err         = err;
    next_state       = state;
    next_mem_req     = mem_req;
    next_readdata    = avs_readdata;
    next_waitrequest = 1'b1;
    if (bus_req)
    begin
      next_waitrequest = 1'b0;
      next_readdata    = UNMAPPED_WORD;
      if (avs_read)
      begin
        unique case (avs_address)
          ADDR_TABLE_BASE_LO: next_readdata = table_base[31:0];
          ADDR_TABLE_BASE_HI: next_readdata = {16'h0000, table_base[ADDR_W-1:32]};
          ADDR_TABLE_CFG:     next_readdata = {19'h0, id_width, 7'h0, table_valid};
          ADDR_ELEMENT_MAP:   next_readdata = {16'h0000, element_id};
          ADDR_STATUS:        next_readdata = {31'h0, idle};
          ADDR_ID4:           next_readdata = {16'h0000, DESC_SIZE};  // RULE9 RULE10 RULE11
          ADDR_ERROR:         next_readdata = {29'h0, err};
          ADDR_PAS_BASE_LO:   next_readdata = pas_base[31:0];
          ADDR_PAS_BASE_HI:   next_readdata = {16'h0000, pas_base[ADDR_W-1:32]};
          ADDR_PAS_LIMIT_LO:  next_readdata = pas_limit[31:0];
          ADDR_PAS_LIMIT_HI:  next_readdata = {16'h0000, pas_limit[ADDR_W-1:32]};
          default:            next_readdata = UNMAPPED_WORD;
        endcase
      end
      else
      begin
        unique case (avs_address)
          ADDR_TABLE_BASE_LO: next_table_base[31:0] = avs_writedata;
          ADDR_TABLE_BASE_HI: next_table_base[ADDR_W-1:32] = avs_writedata[15:0];
          ADDR_TABLE_CFG:
          begin
            next_table_valid = avs_writedata[CFG_VALID_BIT];
            next_id_width    = avs_writedata[CFG_IDW_LSB +: CFG_IDW_W];
          end
          ADDR_ELEMENT_MAP:
          begin
            // a second map while busy is dropped and flagged, not queued
            if (!idle)
              next_err[ERR_BUSY_BIT] = 1'b1;
            else if (table_valid)
            begin
              next_element_id = avs_writedata[15:0];
              next_idle       = 1'b0;  // RULE14
              next_state      = VTM_READ;
            end
          end
          ADDR_ERROR:        next_err = err & ~avs_writedata[2:0];
          ADDR_PAS_BASE_LO:  next_pas_base[31:0] = avs_writedata;
          ADDR_PAS_BASE_HI:  next_pas_base[ADDR_W-1:32] = avs_writedata[15:0];
          ADDR_PAS_LIMIT_LO: next_pas_limit[31:0] = avs_writedata;
          ADDR_PAS_LIMIT_HI: next_pas_limit[ADDR_W-1:32] = avs_writedata[15:0];
          default:           next_err = err;
        endcase
      end
    end
    unique case (state)
      VTM_IDLE:
        next_mem_req = '0;
      VTM_READ:
      begin
        if (!mem_req.rd && !mem_ack)
        begin
          if (!in_range || !in_pas)  // RULE2 RULE16
          begin
            next_err[ERR_RANGE_BIT] = next_err[ERR_RANGE_BIT] | !in_range;
            next_err[ERR_PAS_BIT]   = next_err[ERR_PAS_BIT] | !in_pas;
            next_state              = VTM_DONE;
          end
          else
          begin
            next_mem_req.rd   = 1'b1;
            next_mem_req.addr = entry_addr;  // RULE16
          end
        end
        else if (mem_ack)
        begin
          // read-modify-write keeps the descriptor address field untouched
          // the descriptor is never fetched, so its contents steer no access
          next_mem_req.rd    = 1'b0;
          next_mem_req.wr    = 1'b1;
          next_mem_req.wdata = mem_rdata;  // RULE8 RULE5 RULE6
          next_mem_req.wdata[ENTRY_VALID_BIT] = 1'b1;  // RULE14
          next_state         = VTM_WRITE;
        end
      end
      VTM_WRITE:
      begin
        if (mem_ack)
        begin
          next_mem_req = '0;
          next_state   = VTM_DONE;
        end
      end
      VTM_DONE:
      begin
        next_idle  = 1'b1;  // RULE14
        next_state = VTM_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      table_base      <= '0;
      table_valid     <= 1'b0;
      id_width        <= '0;
      pas_base        <= '0;
      pas_limit       <= '0;
      element_id      <= '0;
      idle            <= 1'b1;
      err             <= '0;
      state           <= VTM_IDLE;
      mem_req         <= '0;
      avs_readdata    <= RESET_WORD;
      avs_waitrequest <= 1'b1;
    end
    else
    begin
      table_base      <= next_table_base;
      table_valid     <= next_table_valid;
      id_width        <= next_id_width;
      pas_base        <= next_pas_base;
      pas_limit       <= next_pas_limit;
      element_id      <= next_element_id;
      idle            <= next_idle;
      err             <= next_err;
      state           <= next_state;
      mem_req         <= next_mem_req;
      avs_readdata    <= next_readdata;
      avs_waitrequest <= next_waitrequest;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  busy_during_write_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE14
    mem_req.wr |-> !idle)
    else $error("idle high during entry write");

  valid_bit_set_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE14
    mem_req.wr |-> mem_req.wdata[ENTRY_VALID_BIT])
    else $error("entry write lacks valid bit");

  idle_after_write_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE14
    (mem_req.wr && mem_ack) |=> ##1 idle)
    else $error("idle not restored two cycles after entry write");

  addr_in_pas_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE2
    (mem_req.rd || mem_req.wr) |->
      (mem_req.addr >= pas_base && mem_req.addr + ADDR_W'(7) <= pas_limit))
    else $error("access outside address window");

  addr_stride_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE12
    (mem_req.rd || mem_req.wr) |->
      (mem_req.addr == table_base + (ADDR_W'(element_id) << ENTRY_SHIFT)))
    else $error("entry address off stride");

  id_bound_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE16 RULE13
    (mem_req.rd || mem_req.wr) |-> ((32'(element_id) >> id_width) == 32'h0))
    else $error("element id beyond table");

  desc_size_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE9
    (!avs_waitrequest && $past(avs_read) && $past(avs_address) == ADDR_ID4)
      |-> avs_readdata[15:0] == DESC_SIZE)
    else $error("descriptor size misreported");

  bus_answer_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");

  map_starts_busy_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE14
    (bus_req && avs_write && avs_address == ADDR_ELEMENT_MAP && idle && table_valid)
      |=> !idle)
    else $error("idle not cleared by mapping write");

  map_done_c: cover property (@(posedge clk_sys) disable iff (!arst_n)
    $rose(idle));
  range_err_c: cover property (@(posedge clk_sys) disable iff (!arst_n)
    $rose(err[ERR_RANGE_BIT]));
  pas_err_c: cover property (@(posedge clk_sys) disable iff (!arst_n)
    $rose(err[ERR_PAS_BIT]));
  busy_err_c: cover property (@(posedge clk_sys) disable iff (!arst_n)
    $rose(err[ERR_BUSY_BIT]));

endmodule : vtm_table_mgr

// ---- verif/vtm_mem_model.sv ----
`timescale 1ns/10ps
module vtm_mem_model
  import vtm_pkg::*;
(
  input  wire logic            clk_sys,
  input  wire logic            arst_n,
  input  wire logic [2:0]      delay,
  input  wire vtm_mem_req_type mem_req,
  output logic                 mem_ack,
  output logic      [63:0]     mem_rdata
);
  // ----------------------------------------------------------------------
  // system memory holding the element table
  // ----------------------------------------------------------------------
  logic [63:0]       mem [logic [ADDR_W-1:0]];
  int                rd_cnt;
  int                wr_cnt;
  logic [ADDR_W-1:0] last_addr;
  logic [2:0]        cnt;

  // one 8-byte word per entry; descriptor areas are never written, so they stay zero
  always @(posedge clk_sys or negedge arst_n)
    if (!arst_n)
    begin
      mem_ack   <= 1'b0;
      mem_rdata <= 64'h0;
      cnt       <= 3'h0;
      rd_cnt    <= 0;
      wr_cnt    <= 0;
      last_addr <= '0;
    end
    else if (mem_ack || !(mem_req.rd || mem_req.wr))
    begin
      // data means nothing outside an answer, so it toggles to expose stale use
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;
      cnt       <= 3'h0;
    end
    else if (cnt < delay)
      cnt <= cnt + 3'h1;
    else
    begin
      mem_ack   <= 1'b1;
      last_addr <= mem_req.addr;
      if (mem_req.wr)
      begin
        mem[mem_req.addr] = mem_req.wdata;
        wr_cnt <= wr_cnt + 1;
      end
      else
      begin
        mem_rdata <= mem.exists(mem_req.addr) ? mem[mem_req.addr] : 64'h0;
        rd_cnt    <= rd_cnt + 1;
      end
    end
endmodule : vtm_mem_model

// ---- verif/vtm_table_mgr_tb.sv ----
`timescale 1ns/10ps
module vtm_table_mgr_tb;
  import vtm_pkg::*;
  localparam logic [15:0] DSZ = 16'h0060;
  logic clk_sys, arst_n, avs_read, avs_write, avs_waitrequest, mem_ack;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q, seed, n;
  logic [63:0] mem_rdata, ini, ini2;
  logic [47:0] base, a;
  logic [15:0] id;
  logic [4:0] idw;
  logic [2:0] delay;
  vtm_mem_req_type mem_req;
  int error_cnt, n_tests, cyc;

  vtm_table_mgr #(.DESC_SIZE(DSZ)) uut (.clk_sys(clk_sys), .arst_n(arst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .mem_req(mem_req), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata));
  vtm_mem_model mdl (.clk_sys(clk_sys), .arst_n(arst_n), .delay(delay), .mem_req(mem_req),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : rnd

  function automatic logic [47:0] ea(input logic [47:0] b, input logic [15:0] i);
    return b + (48'(i) << 3);
  endfunction : ea

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic acc(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int k;
    @(posedge clk_sys);
    avs_address   <= ad;
    avs_writedata <= d;
    avs_write     <= w;
    avs_read      <= !w;
    k = 0;
    do
    begin
      @(posedge clk_sys);
      k++;
    end
    while (avs_waitrequest !== 1'b0 && k < 50);
    if (k == 50)
      error_cnt++;
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : acc

  task automatic rdc(input logic [7:0] ad, input logic [31:0] e);
    acc(1'b0, ad, 32'h0);
    check(q, e);
  endtask : rdc

  task automatic wait_idle();
    int k;
    k = 0;
    do
    begin
      acc(1'b0, ADDR_STATUS, 32'h0);
      k++;
    end
    while (q[STATUS_IDLE_BIT] !== 1'b1 && k < 100);
    check(q, 32'h1);
  endtask : wait_idle

  task automatic map(input logic [15:0] i, input logic ok);
    acc(1'b1, ADDR_ELEMENT_MAP, {16'h0, i});
    if (ok)
      rdc(ADDR_STATUS, 32'h0);
    wait_idle();
  endtask : map

  task automatic setup(input logic [47:0] b, input logic [4:0] w, input logic [31:0] lim);
    acc(1'b1, ADDR_TABLE_BASE_LO, b[31:0]);
    acc(1'b1, ADDR_TABLE_BASE_HI, {16'h0, b[47:32]});
    acc(1'b1, ADDR_PAS_LIMIT_LO, lim);
    acc(1'b1, ADDR_TABLE_CFG, (32'(w) << CFG_IDW_LSB) | 32'h1);
  endtask : setup

  task automatic stop_test();
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : stop_test

  // ----------------------------------------------------------------------
  // clock, timeout and main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      error_cnt++;
      stop_test();
    end
  end

  initial
  begin
    {arst_n, avs_read, avs_write, avs_address, avs_writedata, delay} = '0;
    seed = 32'hd0e19592;
    repeat (20) @(posedge clk_sys);
    arst_n <= 1'b1;
    rdc(ADDR_STATUS, 32'h1);
    acc(1'b1, ADDR_ID4, 32'hffff_ffff);
    rdc(ADDR_ID4, {16'h0, DSZ});
    rdc(ADDR_ERROR, 32'h0);
    rdc(8'hfc, 32'h0);
    acc(1'b1, ADDR_PAS_LIMIT_HI, 32'h0);
    acc(1'b1, ADDR_TABLE_CFG, 32'h0000_0400);
    map(16'h3, 1'b0);
    check(64'(mdl.rd_cnt), 64'h0);
    for (int i = 1; i < 14; i++)
    begin
      idw = (i == 1) ? 5'h10 : 5'(2 + rnd() % 14);
      id = (i < 3) ? 16'((1 << idw) - 1) : 16'(rnd() & ((1 << idw) - 1));
      base = {24'h0, 8'(i), 16'h0} << 8;
      delay <= 3'(rnd());
      setup(base, idw, 32'hffff_ffff);
      // entries start invalid and are never touched again once valid
      ini = {rnd(), rnd() & 32'hffff_fffe};
      a = ea(base, id);
      mdl.mem[a] = ini;
      map(id, 1'b1);
      check(mdl.mem[a], ini | 64'h1);
      check(mdl.last_addr, a);
      n = mdl.rd_cnt;
      if (idw < 16)
      begin
        map(16'(1 << idw), 1'b0);
        rdc(ADDR_ERROR, 32'h1);
        check(64'(mdl.rd_cnt), 64'(n));
        acc(1'b1, ADDR_ERROR, 32'h7);
      end
    end
    // entry one byte past the window is refused, the exact fit is taken
    base = 48'h1_0000;
    a = ea(base, 16'h5);
    setup(base, 5'h4, a[31:0] + 32'h6);
    n = mdl.rd_cnt;
    map(16'h5, 1'b0);
    rdc(ADDR_ERROR, 32'h2);
    check(64'(mdl.rd_cnt), 64'(n));
    acc(1'b1, ADDR_ERROR, 32'h7);
    setup(base, 5'h4, a[31:0] + 32'h7);
    mdl.mem[a] = 64'h0;
    map(16'h5, 1'b1);
    check(mdl.mem[a], 64'h1);
    // entry below the window base is refused as well
    acc(1'b1, ADDR_PAS_BASE_LO, a[31:0] + 32'h1);
    rdc(ADDR_PAS_BASE_LO, a[31:0] + 32'h1);
    n = mdl.rd_cnt;
    map(16'h5, 1'b0);
    rdc(ADDR_ERROR, 32'h2);
    check(64'(mdl.rd_cnt), 64'(n));
    acc(1'b1, ADDR_ERROR, 32'h7);
    acc(1'b1, ADDR_PAS_BASE_LO, 32'h0);
    // open the window so both busy-test entries fit
    acc(1'b1, ADDR_PAS_LIMIT_LO, 32'hffff_ffff);
    // second mapping while busy is dropped
    delay <= 3'h7;
    ini2 = {rnd(), rnd() & 32'hffff_fffe};
    mdl.mem[ea(base, 16'h9)] = ini2;
    mdl.mem[ea(base, 16'h6)] = 64'h0;
    n = mdl.wr_cnt;
    acc(1'b1, ADDR_ELEMENT_MAP, 32'h6);
    acc(1'b1, ADDR_ELEMENT_MAP, 32'h9);
    wait_idle();
    rdc(ADDR_ERROR, 32'h4);
    check(mdl.mem[ea(base, 16'h6)], 64'h1);
    check(mdl.mem[ea(base, 16'h9)], ini2);
    check(64'(mdl.wr_cnt), 64'(n + 1));
    stop_test();
  end
endmodule : vtm_table_mgr_tb
